// ---- bench/serial_ctrl_host_bus_port_bench.sv ----
// Self-checking bench for the host bus port
`timescale 1ns/1ps
module serial_ctrl_host_bus_port_bench;
	logic i_mclk = 1'b0;
	logic i_rst = 1'b1;
	logic chain = 1'b1;
	logic [5:0] pend = 6'h00;
	logic [7:0] rxd, bst, rst_, mst;
	logic [15:0] fc, dcnt;
	wire rd_n, wr_n, ce_n, dc, ack_n, oe_n, tx_load, rx_taken, wr_strobe;
	wire cmd_valid, chain_out, int_n;
	wire [7:0] wdata, o_data, tx_data, wr_value;
	wire [3:0] wr_index;
	wire [2:0] command;
	wire [5:0] insvc;
	logic [7:0] wr[16];
	logic [7:0] ext7;
	logic [7:0] r;
	logic [15:0] evq[$];
	logic [15:0] expq[$];
	int ptr, failures, n_compared, ticks;
	always #5 i_mclk = ~i_mclk;
	shp_host host (.i_mclk(i_mclk), .i_rdata(o_data), .i_rdata_oe_n(oe_n),
		.o_rd_n(rd_n), .o_wr_n(wr_n), .o_ce_n(ce_n), .o_dc(dc),
		.o_ack_n(ack_n), .o_data(wdata));
	shp_port #(.NSRC(6)) DUT (.i_mclk(i_mclk), .i_rst(i_rst),
		.i_rd_n(rd_n), .i_wr_n(wr_n), .i_ce_n(ce_n), .i_dc(dc),
		.i_int_ack_n(ack_n), .i_data(wdata), .i_priority_chain_in(chain),
		.i_pending_bits(pend), .i_rx_data(rxd), .i_base_status(bst),
		.i_rx_status(rst_), .i_misc_status(mst), .i_fifo_count(fc),
		.i_direct_count(dcnt), .o_data(o_data), .o_data_oe_n(oe_n),
		.o_priority_chain_out(chain_out), .o_int_n(int_n),
		.o_tx_data(tx_data), .o_tx_load(tx_load), .o_rx_taken(rx_taken),
		.o_wr_strobe(wr_strobe), .o_wr_index(wr_index),
		.o_wr_value(wr_value), .o_command(command),
		.o_command_valid(cmd_valid), .o_in_service(insvc));
	// Every pulse seen at the outputs, as {kind, index, value}
	always @(posedge i_mclk)
	begin
		if (tx_load === 1'b1) evq.push_back({8'h10, tx_data});
		if (wr_strobe === 1'b1) evq.push_back({4'h2, wr_index, wr_value});
		if (cmd_valid === 1'b1) evq.push_back({8'h30, 5'h00, command});
		if (rx_taken === 1'b1) evq.push_back(16'h4000);
		ticks++;
		// About 1400 cycles are needed; a hang stops here
		if (ticks == 20000)
		begin
			failures++;
			stop_test();
		end
	end
	task automatic chk8(input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e)
		begin
			failures++;
			$display("[ERR] %0t exp %h got %h", $time, e, g);
		end
	endtask
	task automatic chk16(input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e)
		begin
			failures++;
			$display("[ERR] %0t exp %h got %h", $time, e, g);
		end
	endtask
	task automatic chk_ev();
		chk16(16'(expq.size()), 16'(evq.size()));
		while (expq.size() > 0 && evq.size() > 0)
			chk16(expq.pop_front(), evq.pop_front());
		expq.delete();
		evq.delete();
	endtask
	function automatic logic [7:0] rexp(input int p);
		case (p)
			0: return bst;
			1: return rst_;
			2: return wr[9][0] ? {wr[2][7:4], 3'h3, wr[2][0]} : wr[2];
			3: return {2'b00, pend};
			4: return ext7[6] ? wr[4] : bst;
			5: return ext7[6] ? wr[5] : rst_;
			6: return wr[15][2] ? fc[7:0] : dcnt[7:0];
			7: return wr[15][2] ? fc[15:8] : dcnt[15:8];
			8: return rxd;
			9: return ext7[6] ? wr[3] : 8'h00;
			10: return mst;
			14: return ext7[6] ? wr[10] : 8'h00;
			default: return wr[p];
		endcase
	endfunction
	// One access, checked against the register model
	task automatic acc(input logic w, input logic d, input logic [7:0] v);
		logic [7:0] e;
		logic [7:0] g;
		int p;
		p = d ? 8 : ptr;
		e = rexp(p);
		if (p == 8) expq.push_back(w ? {8'h10, v} : 16'h4000);
		else if (w && p == 0) expq.push_back({8'h30, 5'h00, v[5:3]});
		else if (w) expq.push_back({4'h2, 4'(p), v});
		host.cyc(w, d, 1'b0, 1'b1, v, g);
		if (!w) chk8(e, g);
		if (w && p == 7 && wr[15][0]) ext7 = v;
		else if (w && p != 0) wr[p] = v;
		if (!d) ptr = (w && p == 0) ? {v[5:3] == 3'h1, v[2:0]} : 0;
		chk_ev();
	endtask
	task automatic wset(input int i, input logic [7:0] v);
		acc(1'b1, 1'b0, {2'b00, i >= 8 ? 3'h1 : 3'h0, 3'(i)});
		acc(1'b1, 1'b0, v);
	endtask
	task automatic rget(input int i);
		acc(1'b1, 1'b0, {2'b00, i >= 8 ? 3'h1 : 3'h0, 3'(i)});
		acc(1'b0, 1'b0, 8'h00);
	endtask
	task automatic stop_test();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		void'($urandom(32'h9a28));
		rxd <= 8'($urandom());
		bst <= 8'($urandom());
		rst_ <= 8'($urandom());
		mst <= 8'($urandom());
		fc <= 16'($urandom());
		dcnt <= 16'($urandom());
		ext7 = 8'h00;
		foreach (wr[i]) wr[i] = 8'h00;
		repeat (10) @(posedge i_mclk);
		i_rst <= 1'b0;
		repeat (3) acc(1'b1, 1'b1, 8'($urandom()));
		repeat (2) acc(1'b0, 1'b1, 8'h00);
		$display("test direct done");
		pend <= 6'($urandom());
		for (int i = 1; i < 15; i++)
			if (i < 7 || i > 9) wset(i, 8'($urandom()));
		wset(9, 8'h00); // Interrupt mode after the mode registers
		for (int i = 0; i < 15; i++)
			if (i != 11) rget(i);
		wset(15, 8'h04);
		rget(6);
		rget(7);
		$display("test indirect done");
		wset(7, 8'h40);
		rget(4);
		wset(15, 8'h05);
		wset(7, 8'h40 | 8'($urandom()));
		rget(4);
		rget(5);
		rget(9);
		rget(14);
		$display("test readback done");
		pend <= 6'h00;
		wset(2, 8'($urandom()));
		chk8(8'h01, {7'h00, chain_out});
		rget(2);
		wset(9, 8'h01);
		rget(2);
		host.cyc(1'b1, 1'b1, 1'b0, 1'b0, 8'h5A, r);
		chk_ev();
		$display("test vector done");
		wset(2, 8'hA4);
		wset(9, 8'h08);
		pend <= 6'h21;
		repeat (3) @(posedge i_mclk);
		chk8(8'h00, {6'h00, int_n, chain_out});
		host.cyc(1'b0, 1'b0, 1'b1, 1'b1, 8'h00, r);
		chk8(8'hA4, r);
		chk8(8'h20, {2'b00, insvc});
		chk8(8'h02, {6'h00, int_n, chain_out});
		chk_ev();
		acc(1'b1, 1'b0, 8'h38); // Release in-service after ack
		chk8(8'h00, {2'b00, insvc});
		wset(9, 8'h28);
		rget(2);
		chk8(8'h20, {2'b00, insvc});
		acc(1'b1, 1'b0, 8'h38);
		chk8(8'h00, {2'b00, insvc});
		chain <= 1'b0;
		host.cyc(1'b0, 1'b0, 1'b1, 1'b1, 8'h00, r);
		chk8(8'hXX, r);
		chk8(8'h00, {2'b00, insvc});
		chk_ev();
		$display("test acknowledge done");
		stop_test();
	end
endmodule
bind shp_port shp_port_asserts u_chk (.i_mclk(i_mclk), .i_rst(i_rst),
	.i_rd_n(i_rd_n), .i_wr_n(i_wr_n), .i_ce_n(i_ce_n), .i_dc(i_dc),
	.i_int_ack_n(i_int_ack_n), .i_priority_chain_in(i_priority_chain_in),
	.o_data_oe_n(o_data_oe_n), .o_tx_load(o_tx_load),
	.o_rx_taken(o_rx_taken), .o_wr_strobe(o_wr_strobe),
	.o_command_valid(o_command_valid));

// ---- bench/shp_host.sv ----
// Host processor model driving the port's bus pins
`timescale 1ns/1ps
module shp_host
(
	input wire logic i_mclk,
	input wire logic [7:0] i_rdata,
	input wire logic i_rdata_oe_n,
	output logic o_rd_n,
	output logic o_wr_n,
	output logic o_ce_n,
	output logic o_dc,
	output logic o_ack_n,
	output logic [7:0] o_data
);
	initial
	begin
		o_rd_n = 1'b1;
		o_wr_n = 1'b1;
		o_ce_n = 1'b1;
		o_dc = 1'b0;
		o_ack_n = 1'b1;
		o_data = 8'h00;
	end
	// One bus cycle; ack turns a read into an acknowledge
	task automatic cyc(input logic w, input logic d, input logic a,
		input logic ce, input logic [7:0] v, output logic [7:0] r);
		@(posedge i_mclk);
		o_dc <= d;
		o_ack_n <= !a;
		o_data <= ~v;
		repeat (a ? 3 : 1) @(posedge i_mclk); // Chains settle
		o_ce_n <= !ce;
		o_wr_n <= !w;
		o_rd_n <= w;
		repeat (2) @(posedge i_mclk);
		o_data <= v; // Data valid only late in the strobe
		repeat (3) @(posedge i_mclk);
		r = (i_rdata_oe_n === 1'b0) ? i_rdata : 8'hXX;
		o_ce_n <= 1'b1;
		o_wr_n <= 1'b1;
		o_rd_n <= 1'b1;
		@(posedge i_mclk);
		o_ack_n <= 1'b1;
		repeat (6) @(posedge i_mclk); // Recovery time
		o_data <= ~v;
	endtask
endmodule

// ---- bench/shp_port_asserts.sv ----
// Checker on the host bus port pins
`timescale 1ns/1ps
module shp_port_asserts
(
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_rd_n,
	input wire logic i_wr_n,
	input wire logic i_ce_n,
	input wire logic i_dc,
	input wire logic i_int_ack_n,
	input wire logic i_priority_chain_in,
	input wire logic o_data_oe_n,
	input wire logic o_tx_load,
	input wire logic o_rx_taken,
	input wire logic o_wr_strobe,
	input wire logic o_command_valid
);
	logic rd_eff;
	logic wr_eff;
	logic [3:0] rd_gap;
	logic [3:0] wr_gap;
	logic [3:0] next_rd_gap;
	logic [3:0] next_wr_gap;
	assign rd_eff = !i_rd_n && !i_ce_n;
	assign wr_eff = !i_wr_n && !i_ce_n;
	// Cycles since each strobe was last effective, saturating
	always_comb
	begin
		next_rd_gap = rd_eff ? 4'h0 : rd_gap + {3'h0, rd_gap != 4'hF};
		next_wr_gap = wr_eff ? 4'h0 : wr_gap + {3'h0, wr_gap != 4'hF};
	end
	always_ff @(posedge i_mclk)
	begin
		rd_gap <= i_rst ? 4'hF : next_rd_gap;
		wr_gap <= i_rst ? 4'hF : next_wr_gap;
	end
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_rst);
	sequence s_dc_read;
		$rose(rd_eff) && i_dc && i_int_ack_n;
	endsequence
	sequence s_dc_write;
		$fell(wr_eff) && i_dc;
	endsequence
	// Sync stages mean no effect before the second edge
	property p_rd_direct;
		s_dc_read |-> ##[2:5] o_rx_taken;
	endproperty
	property p_wr_direct;
		s_dc_write |-> ##[2:6] o_tx_load;
	endproperty
	property p_oe_cause;
		$fell(o_data_oe_n) |-> $past(rd_eff, 2);
	endproperty
	property p_oe_release;
		rd_gap >= 4'h6 |-> o_data_oe_n;
	endproperty
	property p_wr_cause;
		(o_tx_load || o_wr_strobe || o_command_valid) |-> wr_gap <= 4'h7;
	endproperty
	property p_rx_cause;
		o_rx_taken |-> rd_gap <= 4'h2;
	endproperty
	property p_one_effect;
		o_wr_strobe |-> !o_command_valid && !o_tx_load;
	endproperty
	property p_cmd_pulse;
		o_command_valid |=> !o_command_valid;
	endproperty
	property p_chain_block;
		(rd_eff && !i_int_ack_n && !i_priority_chain_in)[*3] |-> o_data_oe_n;
	endproperty
	a_rd_direct: assert property (p_rd_direct)
		else $error("direct read not taken");
	a_wr_direct: assert property (p_wr_direct)
		else $error("direct write not loaded");
	a_oe_cause: assert property (p_oe_cause)
		else $error("bus driven without read");
	a_oe_release: assert property (p_oe_release)
		else $error("bus still driven");
	a_wr_cause: assert property (p_wr_cause)
		else $error("write effect without strobe");
	a_rx_cause: assert property (p_rx_cause)
		else $error("receive pop without strobe");
	a_one_effect: assert property (p_one_effect)
		else $error("write reached two targets");
	a_cmd_pulse: assert property (p_cmd_pulse)
		else $error("command pulse too long");
	a_chain_block: assert property (p_chain_block)
		else $error("vector driven with chain low");
endmodule

// ---- hw/shp_ack.sv ----
// Interrupt priority resolution and in-service latches
`timescale 1ns/1ps
`include "shp_params.svh"
module shp_ack
#(
	parameter int NSRC = `SHP_NUM_SRC
)
(
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic [NSRC-1:0] i_pending,
	input wire logic i_enable,
	input wire logic i_chain_in,
	input wire logic i_ack,
	input wire logic i_reset_ius,
	output logic [NSRC-1:0] o_ius,
	output logic [2:0] o_src,
	output logic o_has_int,
	output logic o_chain_out
);
	// ----------------------------------------
	// Priority pick
	// ----------------------------------------
	generate
		if (NSRC < 1 || NSRC > 8)
		begin : g_bad_nsrc
			$error("NSRC out of range");
		end
	endgenerate
	logic [NSRC-1:0] in_service_latch;
	logic [NSRC-1:0] next_ius;
	logic [NSRC-1:0] top_ius;
	logic [NSRC-1:0] top_pend;
	logic [2:0] src;
	logic found;
	always_comb
	begin
		top_pend = '0;
		top_ius = '0;
		src = 3'h0;
		found = 1'b0;
		for (int i = NSRC - 1; i >= 0; i--)
		begin
			if (!found && in_service_latch[i])
			begin
				found = 1'b1;
				top_ius[i] = 1'b1;
			end
			else if (!found && i_pending[i] && i_enable)
			begin
				found = 1'b1;
				top_pend[i] = 1'b1;
				src = 3'(i);
			end
		end
		next_ius = in_service_latch;
		if (i_reset_ius)
			next_ius = in_service_latch & ~top_ius;
		// Latch in-service for the source being acknowledged
		if (i_ack && i_chain_in)
			next_ius = next_ius | top_pend;
	end
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
			in_service_latch <= '0;
		else
			in_service_latch <= next_ius;
	end
	assign o_ius = in_service_latch;
	assign o_src = src;
	assign o_has_int = |top_pend;
	assign o_chain_out = i_chain_in & ~(|in_service_latch) & ~(|top_pend);
endmodule

// ---- hw/shp_port.sv ----
// Host bus port of a single channel serial controller
`timescale 1ns/1ps
`include "shp_params.svh"
module shp_port
#(
	parameter int NSRC = `SHP_NUM_SRC
)
(
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_rd_n,
	input wire logic i_wr_n,
	input wire logic i_ce_n,
	input wire logic i_dc,
	input wire logic i_int_ack_n,
	input wire logic [7:0] i_data,
	input wire logic i_priority_chain_in,
	input wire logic [NSRC-1:0] i_pending_bits,
	input wire logic [7:0] i_rx_data,
	input wire logic [7:0] i_base_status,
	input wire logic [7:0] i_rx_status,
	input wire logic [7:0] i_misc_status,
	input wire logic [15:0] i_fifo_count,
	input wire logic [15:0] i_direct_count,
	output logic [7:0] o_data,
	output logic o_data_oe_n,
	output logic o_priority_chain_out,
	output logic o_int_n,
	output logic [7:0] o_tx_data,
	output logic o_tx_load,
	output logic o_rx_taken,
	output logic o_wr_strobe,
	output logic [3:0] o_wr_index,
	output logic [7:0] o_wr_value,
	output logic [2:0] o_command,
	output logic o_command_valid,
	output logic [NSRC-1:0] o_in_service
);
	// ----------------------------------------
	// Strobe handling
	// ----------------------------------------
	shp_pkg::shp_strobes_s pins;
	shp_pkg::shp_access_s acc_start;
	shp_pkg::shp_access_s acc_end;
	logic rd_active;
	assign pins = '{rd_n: i_rd_n, wr_n: i_wr_n, ce_n: i_ce_n,
		dc: i_dc, int_ack_n: i_int_ack_n};
	shp_sync u_sync
	(
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_pins(pins),
		.o_start(acc_start),
		.o_end(acc_end),
		.o_active(rd_active)
	);
	// ----------------------------------------
	// Register state
	// ----------------------------------------
	shp_pkg::shp_state_e state;
	shp_pkg::shp_state_e next_state;
	logic [`SHP_PTR_W-1:0] ptr;
	logic [`SHP_PTR_W-1:0] next_ptr;
	logic [7:0] mode_a;
	logic [7:0] mode_b;
	logic [7:0] mode_c;
	logic [7:0] misc_w;
	logic [7:0] vector;
	logic [7:0] mic;
	logic [7:0] tc_lo;
	logic [7:0] tc_hi;
	logic [7:0] ext_feat;
	logic [7:0] ext_stat;
	logic [7:0] next_mode_a;
	logic [7:0] next_mode_b;
	logic [7:0] next_mode_c;
	logic [7:0] next_misc_w;
	logic [7:0] next_vector;
	logic [7:0] next_mic;
	logic [7:0] next_tc_lo;
	logic [7:0] next_tc_hi;
	logic [7:0] next_ext_feat;
	logic [7:0] next_ext_stat;
	logic [7:0] rd_latch;
	logic [7:0] next_rd_latch;
	logic drive;
	logic next_drive;
	logic [7:0] next_tx_data;
	logic next_tx_load;
	logic next_rx_taken;
	logic next_wr_strobe;
	logic [3:0] next_wr_index;
	logic [7:0] next_wr_value;
	logic [2:0] next_command;
	logic next_command_valid;
	logic ack_go;
	logic reset_ius;
	logic [NSRC-1:0] in_service_latch;
	logic [2:0] src;
	logic has_int;
	logic chain_out;
	logic [3:0] rd_sel;
	// Shared by read selection and vector build
	function automatic logic [7:0] shp_vec(input logic [7:0] base,
		input logic vector_includes_status, input logic [2:0] code, input logic hit);
		logic [7:0] v;
		v = base;
		// Status code replaces vector bits 3..1 when included
		if (vector_includes_status)
			v[3:1] = hit ? code : 3'h3;
		return v;
	endfunction
	// ----------------------------------------
	// Access decode
	// ----------------------------------------
	always_comb
	begin
		next_state = state;
		next_ptr = ptr;
		next_mode_a = mode_a;
		next_mode_b = mode_b;
		next_mode_c = mode_c;
		next_misc_w = misc_w;
		next_vector = vector;
		next_mic = mic;
		next_tc_lo = tc_lo;
		next_tc_hi = tc_hi;
		next_ext_feat = ext_feat;
		next_ext_stat = ext_stat;
		next_rd_latch = rd_latch;
		next_drive = drive;
		next_tx_data = o_tx_data;
		next_tx_load = 1'b0;
		next_rx_taken = 1'b0;
		next_wr_strobe = 1'b0;
		next_wr_index = o_wr_index;
		next_wr_value = o_wr_value;
		next_command = o_command;
		next_command_valid = 1'b0;
		ack_go = 1'b0;
		reset_ius = 1'b0;
		// Direct select overrides the pointer
		rd_sel = acc_start.dc ? `SHP_REG_DATA : ptr;
		case (state)
		shp_pkg::SHP_IDLE:
		begin
			if (acc_start.rd && acc_start.ack)
			begin
				// Hardware acknowledge; vector only if chain in high
				next_drive = has_int && i_priority_chain_in;
				next_rd_latch = shp_vec(vector, mic[`SHP_BIT_VIS], src,
					has_int);
				ack_go = 1'b1;
				next_state = shp_pkg::SHP_ACTIVE;
			end
			else if (acc_start.rd)
			begin
				next_drive = 1'b1;
				next_state = shp_pkg::SHP_ACTIVE;
				// Pointer selects read register
				case (rd_sel)
				4'h0: next_rd_latch = i_base_status;
				`SHP_REG_STAT_RD: next_rd_latch = i_rx_status;
				`SHP_REG_VECTOR:
				begin
					next_rd_latch = shp_vec(vector, mic[`SHP_BIT_VIS],
						src, has_int);
					// Software acknowledge on vector read
					ack_go = mic[`SHP_BIT_SOFT_ACK];
				end
				`SHP_REG_PENDING: next_rd_latch = 8'(i_pending_bits);
				`SHP_REG_RR0_IMG: next_rd_latch =
					ext_feat[`SHP_BIT_WR_READBACK] ? mode_b : i_base_status;
				`SHP_REG_RR1_IMG: next_rd_latch =
					ext_feat[`SHP_BIT_WR_READBACK] ? mode_c : i_rx_status;
				// FIFO contents only while enabled
				`SHP_REG_FRM_LO: next_rd_latch = ext_stat[`SHP_BIT_FIFO_EN]
					? i_fifo_count[7:0] : i_direct_count[7:0];
				`SHP_REG_FRM_HI: next_rd_latch = ext_stat[`SHP_BIT_FIFO_EN]
					? i_fifo_count[15:8] : i_direct_count[15:8];
				`SHP_REG_DATA:
				begin
					next_rd_latch = i_rx_data;
					next_rx_taken = 1'b1;
				end
				// Write register read back through spare slots
				`SHP_REG_RR9_READ: next_rd_latch =
					ext_feat[`SHP_BIT_WR_READBACK] ? mode_a : 8'h00;
				`SHP_REG_MISC: next_rd_latch = i_misc_status;
				`SHP_REG_TC_LO: next_rd_latch = tc_lo;
				`SHP_REG_TC_HI: next_rd_latch = tc_hi;
				`SHP_REG_EXTFEAT_RD: next_rd_latch =
					ext_feat[`SHP_BIT_WR_READBACK] ? misc_w : 8'h00;
				`SHP_REG_EXT_STAT: next_rd_latch = ext_stat;
				default: next_rd_latch = 8'h00;
				endcase
				// Pointer clears after the access
				if (!acc_start.dc)
					next_ptr = '0;
			end
			else if (acc_end.wr)
			begin
				next_state = shp_pkg::SHP_HOLD;
				if (acc_end.dc || ptr == `SHP_REG_DATA)
				begin
					next_tx_data = i_data;
					next_tx_load = 1'b1;
					if (!acc_end.dc)
						next_ptr = '0;
				end
				else if (ptr == '0)
				begin
					// Pointer write names the target
					next_ptr = {1'b0, i_data[2:0]};
					// Point high adds upper bit
					if (i_data[5:3] == `SHP_CMD_POINT_HIGH)
						next_ptr[3] = 1'b1;
					next_command = i_data[5:3];
					next_command_valid = 1'b1;
					reset_ius = i_data[5:3] == `SHP_CMD_RESET_IUS;
				end
				else
				begin
					next_wr_strobe = 1'b1;
					next_wr_index = ptr;
					next_wr_value = i_data;
					case (ptr)
					`SHP_REG_MODE_A: next_mode_a = i_data;
					`SHP_REG_MODE_B: next_mode_b = i_data;
					`SHP_REG_MODE_C: next_mode_c = i_data;
					`SHP_REG_VECTOR: next_vector = i_data;
					`SHP_REG_MIC: next_mic = i_data;
					`SHP_REG_MISC: next_misc_w = i_data;
					`SHP_REG_TC_LO: next_tc_lo = i_data;
					`SHP_REG_TC_HI: next_tc_hi = i_data;
					`SHP_REG_EXT_STAT: next_ext_stat = i_data;
					// Alternate register only when enabled
					`SHP_REG_EXTFEAT:
						if (ext_stat[`SHP_BIT_EXTFEAT_EN])
							next_ext_feat = i_data;
					default: next_wr_strobe = 1'b1;
					endcase
					next_ptr = '0;
				end
			end
		end
		shp_pkg::SHP_ACTIVE:
		begin
			// Data held until the read strobe ends
			if (!rd_active)
			begin
				next_drive = 1'b0;
				next_state = shp_pkg::SHP_IDLE;
			end
		end
		shp_pkg::SHP_HOLD:
			next_state = shp_pkg::SHP_IDLE;
		default:
			next_state = shp_pkg::SHP_IDLE;
		endcase
	end
	shp_ack #(.NSRC(NSRC)) u_ack
	(
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_pending(i_pending_bits),
		.i_enable(mic[`SHP_BIT_MIE]),
		.i_chain_in(i_priority_chain_in),
		.i_ack(ack_go),
		.i_reset_ius(reset_ius),
		.o_ius(in_service_latch),
		.o_src(src),
		.o_has_int(has_int),
		.o_chain_out(chain_out)
	);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			state <= shp_pkg::SHP_IDLE;
			ptr <= '0;
			mode_a <= `SHP_RESET_BYTE;
			mode_b <= `SHP_RESET_BYTE;
			mode_c <= `SHP_RESET_BYTE;
			misc_w <= `SHP_RESET_BYTE;
			vector <= `SHP_RESET_BYTE;
			mic <= `SHP_RESET_BYTE;
			tc_lo <= `SHP_RESET_BYTE;
			tc_hi <= `SHP_RESET_BYTE;
			ext_feat <= `SHP_RESET_BYTE;
			ext_stat <= `SHP_RESET_BYTE;
			rd_latch <= `SHP_RESET_BYTE;
			drive <= 1'b0;
			o_data <= `SHP_RESET_BYTE;
			o_data_oe_n <= 1'b1;
			o_priority_chain_out <= 1'b0;
			o_int_n <= 1'b1;
			o_tx_data <= `SHP_RESET_BYTE;
			o_tx_load <= 1'b0;
			o_rx_taken <= 1'b0;
			o_wr_strobe <= 1'b0;
			o_wr_index <= '0;
			o_wr_value <= `SHP_RESET_BYTE;
			o_command <= 3'h0;
			o_command_valid <= 1'b0;
			o_in_service <= '0;
		end
		else
		begin
			state <= next_state;
			ptr <= next_ptr;
			mode_a <= next_mode_a;
			mode_b <= next_mode_b;
			mode_c <= next_mode_c;
			misc_w <= next_misc_w;
			vector <= next_vector;
			mic <= next_mic;
			tc_lo <= next_tc_lo;
			tc_hi <= next_tc_hi;
			ext_feat <= next_ext_feat;
			ext_stat <= next_ext_stat;
			rd_latch <= next_rd_latch;
			drive <= next_drive;
			o_data <= next_rd_latch;
			o_data_oe_n <= ~next_drive;
			o_priority_chain_out <= chain_out;
			o_int_n <= ~has_int;
			o_tx_data <= next_tx_data;
			o_tx_load <= next_tx_load;
			o_rx_taken <= next_rx_taken;
			o_wr_strobe <= next_wr_strobe;
			o_wr_index <= next_wr_index;
			o_wr_value <= next_wr_value;
			o_command <= next_command;
			o_command_valid <= next_command_valid;
			o_in_service <= in_service_latch;
		end
	end
endmodule

// ---- hw/shp_sync.sv ----
// Strobe synchroniser and access event generator
`timescale 1ns/1ps
`include "shp_params.svh"
module shp_sync
(
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire shp_pkg::shp_strobes_s i_pins,
	output shp_pkg::shp_access_s o_start,
	output shp_pkg::shp_access_s o_end,
	output logic o_active
);
	// ----------------------------------------
	// Two-stage synchroniser
	// ----------------------------------------
	logic [1:0] meta;
	logic [1:0] sync;
	logic [1:0] next_meta;
	logic [1:0] next_sync;
	logic [1:0] prev;
	logic [1:0] next_prev;
	logic dc_q;
	logic ack_q;
	logic next_dc_q;
	logic next_ack_q;
	shp_pkg::shp_access_s next_start;
	shp_pkg::shp_access_s next_end;
	always_comb
	begin
		// Strobe counts only while chip enable is low
		next_meta = {~i_pins.rd_n & ~i_pins.ce_n,
			~i_pins.wr_n & ~i_pins.ce_n};
		// First stage read only here, time for metastability
		next_sync = meta;
		next_prev = sync;
		next_dc_q = i_pins.dc;
		next_ack_q = ~i_pins.int_ack_n;
		next_start = '0;
		next_end = '0;
		next_start.rd = sync[1] & ~prev[1];
		next_start.wr = sync[0] & ~prev[0];
		next_start.dc = dc_q;
		next_start.ack = ack_q;
		// Writes act at strobe end, data need not be valid early
		next_end.rd = ~sync[1] & prev[1];
		next_end.wr = ~sync[0] & prev[0];
		next_end.dc = dc_q;
		next_end.ack = ack_q;
	end
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			meta <= '0;
			sync <= '0;
			prev <= '0;
			dc_q <= 1'b0;
			ack_q <= 1'b0;
			o_start <= '0;
			o_end <= '0;
		end
		else
		begin
			meta <= next_meta;
			sync <= next_sync;
			prev <= next_prev;
			dc_q <= next_dc_q;
			ack_q <= next_ack_q;
			o_start <= next_start;
			o_end <= next_end;
		end
	end
	assign o_active = sync[1];
endmodule

// ---- inc/shp_params.svh ----
// Constants for the serial controller host bus port
`ifndef SHP_PARAMS_SVH
`define SHP_PARAMS_SVH
`define SHP_RECOVERY_CLKS 3'h4
`define SHP_PTR_W 4
`define SHP_REG_DATA 4'h8
`define SHP_REG_VECTOR 4'h2
`define SHP_REG_PENDING 4'h3
`define SHP_REG_MODE_A 4'h3
`define SHP_REG_MODE_B 4'h4
`define SHP_REG_MODE_C 4'h5
`define SHP_REG_FRM_LO 4'h6
`define SHP_REG_FRM_HI 4'h7
`define SHP_REG_MIC 4'h9
`define SHP_REG_MISC 4'hA
`define SHP_REG_TC_LO 4'hC
`define SHP_REG_TC_HI 4'hD
`define SHP_REG_EXTFEAT_RD 4'hE
`define SHP_REG_STAT_RD 4'h1
`define SHP_REG_EXT_STAT 4'hF
`define SHP_REG_EXTFEAT 4'h7
`define SHP_REG_RR0_IMG 4'h4
`define SHP_REG_RR1_IMG 4'h5
`define SHP_REG_RR9_READ 4'h9
`define SHP_CMD_POS 3
`define SHP_CMD_POINT_HIGH 3'h1
`define SHP_CMD_RESET_IUS 3'h7
`define SHP_BIT_EXTFEAT_EN 0
`define SHP_BIT_FIFO_EN 2
`define SHP_BIT_WR_READBACK 6
`define SHP_BIT_VIS 0
`define SHP_BIT_SOFT_ACK 5
`define SHP_BIT_MIE 3
`define SHP_RESET_BYTE 8'h00
`define SHP_NUM_SRC 6
`endif

// ---- inc/shp_pkg.sv ----
// Types for the serial controller host bus port
package shp_pkg;
	typedef struct packed {
		logic rd_n;
		logic wr_n;
		logic ce_n;
		logic dc;
		logic int_ack_n;
	} shp_strobes_s;
	typedef struct packed {
		logic rd;
		logic wr;
		logic ack;
		logic dc;
	} shp_access_s;
	typedef enum logic [1:0] {
		SHP_IDLE = 2'b00,
		SHP_ACTIVE = 2'b01,
		SHP_HOLD = 2'b10
	} shp_state_e;
endpackage
